// ==== rtl/sei_pkg.sv ====
// sei_pkg: constants, enums and carrier types of the two-wire memory slave
// assumes a 125 MHz system clock; the bus lines arrive asynchronously
package sei_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 8;

  // input noise suppression, standard and fast bus speed
  localparam int GLITCH_STD_NS = 100;
  localparam int GLITCH_FAST_NS = 50;
  localparam logic [3:0] GLITCH_STD_CYC =
    4'((GLITCH_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] GLITCH_FAST_CYC =
    4'((GLITCH_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // internal program time, standard and low-voltage supply
  localparam int PROG_STD_MS = 10;
  localparam int PROG_LV_MS = 15;
  localparam int PROG_STD_CYC = (PROG_STD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int PROG_LV_CYC = (PROG_LV_MS * 1000000) / CLK_PERIOD_NS;
  localparam int PROG_CNT_W = 21;

  // framing and array layout
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int MEM_DEPTH = 256;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_LSB_W = 4;
  localparam logic RW_READ = 1'b1;
  localparam logic [7:0] MEM_RESET = 8'hFF;

  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_TXACK, S_WAIT} sei_state_e;
  typedef enum logic [1:0] {PH_ADDR, PH_WADDR, PH_DATA} sei_phase_e;

  // filtered bus line levels
  typedef struct packed {
    logic scl;
    logic sda;
  } sei_bus_s;

endpackage

// ==== rtl/sei_line_filter.sv ====
// sei_line_filter: two-stage synchroniser followed by a stability filter
// assumes line_in is asynchronous and thresh_in is a quasi-static level
`timescale 1ns/1ps
`default_nettype none
module sei_line_filter
  import sei_pkg::*;
(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       nrst_in,
  // line
  input  wire logic       line_in,
  input  wire logic [3:0] thresh_in,
  output logic            line_out
);

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       filt;
    logic [3:0] cnt;
  } sei_filt_s;

  sei_filt_s r_reg;
  sei_filt_s r_next;

  // new level must hold thresh_in cycles; shorter pulses vanish
  always_comb begin
    r_next = r_reg;
    r_next.s1 = line_in;
    r_next.s2 = r_reg.s1;
    if (r_reg.s2 == r_reg.filt) begin
      r_next.cnt = 4'h0;
    end else if (r_reg.cnt == thresh_in - 4'h1) begin
      r_next.filt = r_reg.s2; // RULE3
      r_next.cnt = 4'h0;
    end else begin
      r_next.cnt = r_reg.cnt + 4'h1;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r_reg <= '{s1: 1'b1, s2: 1'b1, filt: 1'b1, cnt: 4'h0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign line_out = r_reg.filt;

  chk_glitch_reject: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE3
    (r_reg.filt != $past(r_reg.filt)) |-> ($past(r_reg.cnt) == $past(thresh_in) - 4'h1))
    else $error("filtered line changed before the pulse was long enough");

endmodule
`default_nettype wire

// ==== rtl/sei_prog_timer.sv ====
// sei_prog_timer: self-timed program cycle, busy while it runs
// assumes start_in is a one-cycle pulse from the slave logic
`timescale 1ns/1ps
`default_nettype none
module sei_prog_timer
  import sei_pkg::*;
#(
  parameter int STD_CYC = PROG_STD_CYC,
  parameter int LV_CYC  = PROG_LV_CYC
)
(
  // clock and reset
  input  wire logic clock_in,
  input  wire logic nrst_in,
  // control
  input  wire logic start_in,
  input  wire logic low_vcc_in,
  output logic      busy_out
);

  typedef struct packed {
    logic [PROG_CNT_W-1:0] cnt;
    logic                 busy;
  } sei_tmr_s;

  sei_tmr_s r_reg;
  sei_tmr_s r_next;

  always_comb begin
    r_next = r_reg;
    if (start_in && !r_reg.busy) begin
      r_next.busy = 1'b1;
      r_next.cnt = low_vcc_in ? PROG_CNT_W'(LV_CYC) : PROG_CNT_W'(STD_CYC); // RULE1
    end else if (r_reg.busy) begin
      if (r_reg.cnt == PROG_CNT_W'(1)) begin
        r_next.busy = 1'b0;
        r_next.cnt = '0;
      end else begin
        r_next.cnt = r_reg.cnt - PROG_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign busy_out = r_reg.busy;

  chk_cycle_bound: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE1
    r_reg.busy |-> (r_reg.cnt != '0 && r_reg.cnt <= PROG_CNT_W'(LV_CYC)))
    else $error("program cycle count outside its bound");

  chk_cycle_load: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE1
    $rose(r_reg.busy) |->
      r_reg.cnt == ($past(low_vcc_in) ? PROG_CNT_W'(LV_CYC) : PROG_CNT_W'(STD_CYC)))
    else $error("program cycle started with the wrong length");

endmodule
`default_nettype wire

// ==== rtl/sei_slave.sv ====
// sei_slave: two-wire slave of a 256-byte memory with self-timed writes
// assumes an external master drives the clock line and pull-ups on both lines
//
// Behaviour
// [RULE1] program cycle ends within 10 ms, or 15 ms on low supply
// [RULE2] during the program cycle the bus is ignored and data left released
// [RULE3] pulses under 100 ns, or 50 ns in fast mode, are rejected
// [RULE4] address starts with a 4-bit device type, compared against the code
// [RULE5] next three address bits must match the strap pins
// [RULE6] data changes only while the clock is low; else start or stop
// [RULE7] falling data with clock high is start; nothing happens before one
// [RULE8] rising data with clock high is stop; transfer ends, back to standby
// [RULE9] sender releases after eight bits; receiver pulls low on ninth clock
// [RULE10] a matching address after start is acknowledged, except while the program cycle runs
// [RULE11] once selected for write, every further byte is acknowledged
// [RULE12] read mode sends eight bits, samples acknowledge, continues on it
// [RULE13] missing acknowledge in read mode ends sending until stop
// [RULE14] data line only pulled low or released, never driven high
// [RULE15] master starts every transfer and supplies the clock
// [RULE16] a 16-byte page is written per cycle; address wraps inside page
// [RULE17] last address bit: one reads, zero writes
// [RULE18] a write names one of 256 bytes in its second byte
// [RULE19] lines filtered and synchronised; edges found from the clean copies
`timescale 1ns/1ps
`default_nettype none
module sei_slave
  import sei_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = 4'h3, // arbitrary value
  parameter int         STD_CYC  = PROG_STD_CYC,
  parameter int         LV_CYC   = PROG_LV_CYC
)
(
  // clock and reset
  input  wire logic clock_in,
  input  wire logic nrst_in,
  // bus lines
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  // straps and variant
  input  wire logic chip_select_strap_0_in,
  input  wire logic chip_select_strap_1_in,
  input  wire logic chip_select_strap_2_in,
  input  wire logic fast_mode_in,
  input  wire logic low_vcc_in,
  // status
  output logic      busy_out
);

  typedef struct packed {
    sei_state_e                      state;
    sei_phase_e                      phase;
    logic [3:0]                      cnt;
    logic [7:0]                      sh;
    logic [7:0]                      ptr;
    logic                            rw;
    logic                            dirty;
    logic                            wr_go;
    logic                            oe;
    logic                            drv;
    logic                            scl_p;
    logic                            sda_p;
    logic [1:0]                      m1;
    logic [1:0]                      m2;
    logic [2:0]                      a1;
    logic [2:0]                      a2;
    logic [MEM_DEPTH-1:0][7:0]       mem;
  } sei_slave_s;

  sei_slave_s r_reg;
  sei_slave_s r_next;
  sei_bus_s   ln;
  logic       busy;
  logic [3:0] thresh;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       addr_hit;

  // fast mode shortens the rejection window
  assign thresh = r_reg.m2[1] ? GLITCH_FAST_CYC : GLITCH_STD_CYC; // RULE3

  sei_line_filter u_scl_filt (
    .clock_in  (clock_in),
    .nrst_in   (nrst_in),
    .line_in   (scl_in),
    .thresh_in (thresh),
    .line_out  (ln.scl)
  );

  sei_line_filter u_sda_filt (
    .clock_in  (clock_in),
    .nrst_in   (nrst_in),
    .line_in   (sda_in),
    .thresh_in (thresh),
    .line_out  (ln.sda)
  );

  sei_prog_timer #(
    .STD_CYC (STD_CYC),
    .LV_CYC  (LV_CYC)
  ) u_timer (
    .clock_in   (clock_in),
    .nrst_in    (nrst_in),
    .start_in   (r_reg.wr_go),
    .low_vcc_in (r_reg.m2[0]),
    .busy_out   (busy)
  );

  // edges from the filtered copies only
  assign rise  = ln.scl && !r_reg.scl_p; // RULE19
  assign fall  = !ln.scl && r_reg.scl_p; // RULE19
  // data moving under a steady high clock is framing, never data
  assign start = ln.scl && r_reg.scl_p && !ln.sda && r_reg.sda_p; // RULE6 RULE7
  assign stop  = ln.scl && r_reg.scl_p && ln.sda && !r_reg.sda_p; // RULE6 RULE8

  // type code, then strap pins, then direction bit
  assign addr_hit = (r_reg.sh[7:4] == DEV_TYPE) && (r_reg.sh[3:1] == r_reg.a2); // RULE4 RULE5

  always_comb begin
    r_next = r_reg;
    r_next.wr_go = 1'b0;
    r_next.drv = 1'b0; // RULE14
    r_next.m1 = {fast_mode_in, low_vcc_in};
    r_next.m2 = r_reg.m1;
    r_next.a1 = {chip_select_strap_2_in, chip_select_strap_1_in, chip_select_strap_0_in};
    r_next.a2 = r_reg.a1;
    r_next.scl_p = ln.scl;
    r_next.sda_p = ln.sda;
    if (stop) begin
      r_next.state = S_IDLE; // RULE8
      r_next.oe = 1'b0;
      r_next.wr_go = r_reg.dirty; // RULE1
      r_next.dirty = 1'b0;
    end else if (start) begin
      // bus is deaf while the program cycle runs
      r_next.oe = 1'b0;
      r_next.cnt = 4'h0;
      r_next.phase = PH_ADDR;
      r_next.state = busy ? S_IDLE : S_RX; // RULE2 RULE7
    end else begin
      case (r_reg.state)
        S_RX: begin
          if (rise && r_reg.cnt < BITS_PER_BYTE) begin
            r_next.sh = {r_reg.sh[6:0], ln.sda};
            r_next.cnt = r_reg.cnt + 4'h1;
          end else if (fall && r_reg.cnt == BITS_PER_BYTE) begin
            case (r_reg.phase)
              PH_ADDR: begin
                if (addr_hit) begin
                  r_next.oe = 1'b1; // RULE9 RULE10
                  r_next.rw = r_reg.sh[0]; // RULE17
                  r_next.state = S_ACK;
                end else begin
                  r_next.state = S_IDLE;
                end
              end
              PH_WADDR: begin
                r_next.ptr = r_reg.sh; // RULE18
                r_next.oe = 1'b1; // RULE11
                r_next.state = S_ACK;
              end
              default: begin
                r_next.mem[r_reg.ptr] = r_reg.sh;
                // roll over inside the current page
                r_next.ptr = {r_reg.ptr[7:PAGE_LSB_W],
                              r_reg.ptr[PAGE_LSB_W-1:0] + 4'h1}; // RULE16
                r_next.dirty = 1'b1;
                r_next.oe = 1'b1; // RULE11
                r_next.state = S_ACK;
              end
            endcase
          end
        end
        S_ACK: begin
          if (fall) begin
            r_next.oe = 1'b0; // RULE9
            r_next.cnt = 4'h0;
            if (r_reg.phase == PH_ADDR && r_reg.rw == RW_READ) begin
              r_next.sh = r_reg.mem[r_reg.ptr];
              r_next.oe = ~r_reg.mem[r_reg.ptr][7]; // RULE12 RULE14
              r_next.ptr = r_reg.ptr + 8'h01;
              r_next.state = S_TX;
            end else begin
              r_next.phase = (r_reg.phase == PH_ADDR) ? PH_WADDR : PH_DATA;
              r_next.state = S_RX;
            end
          end
        end
        S_TX: begin
          if (rise && r_reg.cnt < BITS_PER_BYTE) begin
            r_next.cnt = r_reg.cnt + 4'h1;
          end else if (fall && r_reg.cnt == BITS_PER_BYTE) begin
            r_next.oe = 1'b0; // RULE12
            r_next.state = S_TXACK;
          end else if (fall) begin
            r_next.sh = {r_reg.sh[6:0], 1'b0};
            r_next.oe = ~r_reg.sh[6]; // RULE14
          end
        end
        S_TXACK: begin
          if (rise && ln.sda) begin
            r_next.state = S_WAIT; // RULE13
          end else if (fall) begin
            r_next.sh = r_reg.mem[r_reg.ptr];
            r_next.oe = ~r_reg.mem[r_reg.ptr][7]; // RULE12
            r_next.ptr = r_reg.ptr + 8'h01;
            r_next.cnt = 4'h0;
            r_next.state = S_TX;
          end
        end
        S_WAIT: begin
          r_next.oe = 1'b0; // RULE13
        end
        default: begin
          r_next.oe = 1'b0;
        end
      endcase
    end
  end

  // array kept in flops; cleared to erased state only at power-up reset
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r_reg.state <= S_IDLE;
      r_reg.phase <= PH_ADDR;
      r_reg.cnt   <= 4'h0;
      r_reg.sh    <= 8'h00;
      r_reg.ptr   <= 8'h00;
      r_reg.rw    <= 1'b0;
      r_reg.dirty <= 1'b0;
      r_reg.wr_go <= 1'b0;
      r_reg.oe    <= 1'b0;
      r_reg.drv   <= 1'b0;
      r_reg.scl_p <= 1'b1;
      r_reg.sda_p <= 1'b1;
      r_reg.m1    <= 2'h0;
      r_reg.m2    <= 2'h0;
      r_reg.a1    <= 3'h0;
      r_reg.a2    <= 3'h0;
      r_reg.mem   <= {MEM_DEPTH{MEM_RESET}};
    end else begin
      r_reg <= r_next;
    end
  end

  assign sda_out    = r_reg.drv;
  assign sda_oe_out = r_reg.oe;
  assign busy_out   = busy;

  chk_busy_released: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE2
    busy |-> (!sda_oe_out && r_reg.state == S_IDLE))
    else $error("bus touched during the program cycle");

  chk_drive_low: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE14
    sda_oe_out |-> !sda_out)
    else $error("data line driven high");

  chk_start_enter: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE7
    (start && !busy) |=> (r_reg.state == S_RX && r_reg.phase == PH_ADDR && r_reg.cnt == 4'h0))
    else $error("start not taken");

  chk_stop_idle: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE8
    stop |=> (r_reg.state == S_IDLE && !sda_oe_out))
    else $error("stop did not return to standby");

  chk_addr_reject: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE5
    (!start && !stop && fall && r_reg.state == S_RX && r_reg.phase == PH_ADDR
     && r_reg.cnt == BITS_PER_BYTE && !addr_hit) |=> (r_reg.state == S_IDLE && !sda_oe_out))
    else $error("foreign address acknowledged");

  chk_write_ack: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE11
    (!start && !stop && fall && r_reg.state == S_RX && r_reg.phase != PH_ADDR
     && r_reg.cnt == BITS_PER_BYTE) |=> (sda_oe_out && r_reg.state == S_ACK))
    else $error("write byte not acknowledged");

  chk_nack_wait: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE13
    (!start && !stop && rise && ln.sda && r_reg.state == S_TXACK)
      |=> (r_reg.state == S_WAIT) ##1 !sda_oe_out)
    else $error("read continued without acknowledge");

  chk_page_wrap: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE16
    (r_reg.dirty && $changed(r_reg.ptr) && r_reg.state == S_ACK && r_reg.phase == PH_DATA)
      |-> (r_reg.ptr[7:PAGE_LSB_W] == $past(r_reg.ptr[7:PAGE_LSB_W])))
    else $error("page write left its page");

  chk_stop_program: assert property (@(posedge clock_in) disable iff (!nrst_in) // RULE1
    (stop && r_reg.dirty && !busy) |=> ##1 busy)
    else $error("program cycle not started after stop");

endmodule
`default_nettype wire

// ==== verif/sei_bus_master.sv ====
// sei_bus_master: behavioural two-wire bus master for the slave bench
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module sei_bus_master (
  // clock
  input  wire logic       clock_in,
  // bus
  input  wire logic       sda_in,
  input  wire logic [4:0] quarter_in,
  output var  logic       scl_out,
  output var  logic       sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic q(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // also serves as repeated start from clock low
  task automatic start();
    // let the slave drop its acknowledge before the clock rises
    q(int'(quarter_in));
    sda_low_out <= 1'b0;
    q(int'(quarter_in));
    scl_out <= 1'b1;
    q(2 * int'(quarter_in));
    sda_low_out <= 1'b1;
    q(2 * int'(quarter_in));
    scl_out <= 1'b0;
    q(int'(quarter_in));
  endtask

  task automatic stop();
    q(int'(quarter_in));
    sda_low_out <= 1'b1;
    q(int'(quarter_in));
    scl_out <= 1'b1;
    q(2 * int'(quarter_in));
    sda_low_out <= 1'b0;
    q(2 * int'(quarter_in));
  endtask

  // g > 0 adds a short high pulse on a low bit while the clock is high
  task automatic xfer_bit(input logic b, input int g, output logic s);
    // slave answers a filter delay after the fall; low phase must outlast it
    q(int'(quarter_in));
    sda_low_out <= ~b;
    q(int'(quarter_in));
    scl_out <= 1'b1;
    q(int'(quarter_in));
    @(negedge clock_in);
    s = sda_in;
    @(posedge clock_in);
    if (g > 0 && !b) begin
      sda_low_out <= 1'b0;
      q(g);
      sda_low_out <= 1'b1;
    end
    q(int'(quarter_in));
    scl_out <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] b, input int g, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(b[i], (i == 7) ? g : 0, s);
    end
    xfer_bit(1'b1, 0, s);
    ack = ~s;
  endtask

  task automatic rd(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, 0, s);
      b[i] = s;
    end
    xfer_bit(~ack, 0, s);
  endtask
endmodule
`default_nettype wire

// ==== verif/sei_slave_tb.sv ====
// sei_slave_tb: self-checking bench with a byte-array model of the memory
// assumes sei_bus_master as the far side; program time shortened
`timescale 1ns/1ps
`default_nettype none
module sei_slave_tb
  import sei_pkg::*;
;
  localparam logic [3:0] DEV = 4'h9; // arbitrary value
  localparam int STD = 1000;
  localparam int LV = 1500;

  logic       clock_in;
  logic       nrst_in;
  logic [2:0] straps;
  logic       fast;
  logic       low_vcc;
  logic [4:0] quarter;
  logic [7:0] mem [256];
  logic [7:0] wa;
  logic [7:0] a;
  logic       ack;
  int         err_total;
  int         n_checks;
  int         run_len;
  int         last_len;
  wire logic  scl;
  wire logic  m_low;
  wire logic  sda_oe;
  wire logic  sda_drv;
  wire logic  busy;
  wire logic  sda;

  assign sda = ~(sda_oe | m_low);

  sei_slave #(.DEV_TYPE(DEV), .STD_CYC(STD), .LV_CYC(LV)) u_dut (
    .clock_in               (clock_in),
    .nrst_in                (nrst_in),
    .scl_in                 (scl),
    .sda_in                 (sda),
    .sda_out                (sda_drv),
    .sda_oe_out             (sda_oe),
    .chip_select_strap_0_in (straps[0]),
    .chip_select_strap_1_in (straps[1]),
    .chip_select_strap_2_in (straps[2]),
    .fast_mode_in           (fast),
    .low_vcc_in             (low_vcc),
    .busy_out               (busy)
  );

  sei_bus_master u_master (
    .clock_in    (clock_in),
    .sda_in      (sda),
    .quarter_in  (quarter),
    .scl_out     (scl),
    .sda_low_out (m_low)
  );

  always #(CLK_PERIOD_NS / 2) clock_in = ~clock_in;

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // sampled away from the launching edge
  always @(negedge clock_in) begin
    if (busy === 1'b1) run_len <= run_len + 1;
    else if (run_len != 0) begin
      last_len <= run_len;
      run_len <= 0;
    end
    if (sda_oe === 1'b1) chk("sda_level", sda_drv, 8'h00);
    if (busy === 1'b1) chk("oe_busy", sda_oe, 8'h00);
  end

  task automatic do_write(input logic [7:0] w, input int n, input int g, input int lim);
    logic       k_ack;
    logic [7:0] d;
    int         k;
    u_master.start();
    u_master.wr({DEV, straps, 1'b0}, 0, k_ack);
    chk("ack_wr_addr", k_ack, 8'h01);
    u_master.wr(w, 0, k_ack);
    chk("ack_byte_addr", k_ack, 8'h01);
    for (k = 0; k < n; k++) begin
      d = 8'($urandom) & ((g > 0) ? 8'h7F : 8'hFF);
      u_master.wr(d, g, k_ack);
      chk("ack_data", k_ack, 8'h01);
      mem[{w[7:4], 4'(w[3:0] + k)}] = d;
    end
    u_master.stop();
    k = 0;
    while (busy !== 1'b1 && k < 40) begin
      @(negedge clock_in);
      k++;
    end
    chk("busy_start", busy, 8'h01);
    // polling is run only at fast speed, inside the short cycle
    if (fast) begin
      u_master.start();
      u_master.wr({DEV, straps, 1'b0}, 0, k_ack);
      chk("ack_poll", k_ack, 8'h00);
      u_master.stop();
    end
    while (busy !== 1'b0 && k < 4000) begin
      @(negedge clock_in);
      k++;
    end
    repeat (2) @(negedge clock_in);
    chk("busy_len", 8'(last_len <= lim && last_len + 2 >= lim), 8'h01);
  endtask

  task automatic do_read(input logic [7:0] r, input int n);
    logic       k_ack;
    logic [7:0] b;
    u_master.start();
    u_master.wr({DEV, straps, 1'b0}, 0, k_ack);
    u_master.wr(r, 0, k_ack);
    chk("ack_rd_ptr", k_ack, 8'h01);
    u_master.start();
    u_master.wr({DEV, straps, 1'b1}, 0, k_ack);
    chk("ack_rd_addr", k_ack, 8'h01);
    for (int k = 0; k < n; k++) begin
      u_master.rd(k < n - 1, b);
      chk("rd_data", b, mem[8'(r + k)]);
    end
    u_master.rd(1'b0, b);
    chk("rd_after_nack", b, 8'hFF);
    u_master.stop();
  endtask

  task automatic set_mode(input logic f, input logic lv, input logic [4:0] qt);
    @(posedge clock_in);
    fast <= f;
    low_vcc <= lv;
    quarter <= qt;
    repeat (8) @(posedge clock_in);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #(400000);
    err_total++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(83));
    clock_in = 1'b0;
    nrst_in = 1'b0;
    straps = 3'($urandom);
    fast = 1'b1;
    low_vcc = 1'b0;
    quarter = 5'h08;
    foreach (mem[i]) mem[i] = MEM_RESET;
    run_len = 0;
    last_len = 0;
    err_total = 0;
    n_checks = 0;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (6) @(negedge clock_in);
    chk("oe_reset", sda_oe, 8'h00);
    chk("busy_reset", busy, 8'h00);
    for (int i = 0; i < 4; i++) begin
      a = {DEV, straps, 1'b0};
      if (i == 0) a[7:4] = ~DEV;
      else a[i] = ~a[i];
      u_master.start();
      u_master.wr(a, 0, ack);
      chk("ack_foreign", ack, 8'h00);
      u_master.wr({DEV, straps, 1'b0}, 0, ack);
      chk("ack_no_start", ack, 8'h00);
      u_master.stop();
    end
    wa = 8'($urandom);
    do_write(wa, 17, 0, STD);
    do_read({wa[7:4], 4'h0}, 16);
    set_mode(1'b0, 1'b1, 5'h10);
    wa = 8'($urandom);
    do_write(wa, 3, 10, LV);
    do_read(wa, 3);
    set_mode(1'b1, 1'b0, 5'h08);
    wa = 8'($urandom);
    do_write(wa, 2, 5, STD);
    do_read(wa, 2);
    tally_and_finish();
  end
endmodule
`default_nettype wire
